// [verilog/sap_pkg.sv]
/*
  Shared constants and types for the secondary audio serial port block:
  register indexes, field positions, write masks, reset values and codes.
  Assumes a 32-bit AXI4-Lite bus where byte address = 4 * register index.
*/
package sap_pkg;

  // ------------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [7:0] IDX_FMT   = 8'h11;  // port_frame_format_control
  localparam logic [7:0] IDX_OFS   = 8'h12;  // port_data_offset
  localparam logic [7:0] IDX_RSV_A = 8'h13;  // reserved_a
  localparam logic [7:0] IDX_RSV_B = 8'h14;  // reserved_b
  localparam logic [7:0] IDX_ADC   = 8'h15;  // adc_path_format_control
  localparam logic [7:0] IDX_RSV_C = 8'h16;  // reserved_c
  localparam logic [7:0] IDX_SRC   = 8'h17;  // serial_output_source_select
  localparam logic [7:0] IDX_RT    = 8'h18;  // dac_channel_routing
  localparam logic [7:0] IDX_RSV_D = 8'h19;  // reserved_d
  localparam logic [7:0] IDX_STAT  = 8'h1f;  // port status (read only)

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int FMT_POS  = 5;  // Format code, 3 bits
  localparam int WL_POS   = 3;  // Word length code, 2 bits
  localparam int TRI_POS  = 0;  // Release output after word
  localparam int OVR_POS  = 2;  // Separate format for output path
  localparam int LRT_POS  = 6;  // Left DAC route, 2 bits
  localparam int RRT_POS  = 4;  // Right DAC route, 2 bits
  localparam int ACT_POS  = 0;  // Status: frames seen on the link
  localparam int PEND_POS = 1;  // Status: settings not yet at link

  // ------------------------------------------------------------------
  // Write masks (reserved bits stay zero) and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] WM_FMT  = 8'hf9;
  localparam logic [7:0] WM_OFS  = 8'hff;
  localparam logic [7:0] WM_ADC  = 8'hfc;
  localparam logic [7:0] WM_SRC  = 8'h07;
  localparam logic [7:0] WM_RT   = 8'hf0;
  localparam logic [7:0] RST_FMT = 8'h00;
  localparam logic [7:0] RST_OFS = 8'h00;
  localparam logic [7:0] RST_ADC = 8'h00;
  localparam logic [7:0] RST_SRC = 8'h00;
  localparam logic [7:0] RST_RT  = 8'h00;

  // ------------------------------------------------------------------
  // Codes
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {SAP_I2S, SAP_DSP, SAP_RJF, SAP_LJF, SAP_MONO} sap_fmt_e;
  typedef enum logic [2:0] {
    SAP_SRC_OFF, SAP_SRC_DSP12, SAP_SRC_LB1, SAP_SRC_LB2, SAP_SRC_LB3, SAP_SRC_DSP34
  } sap_src_e;
  typedef enum logic [1:0] {SAP_RT_OFF, SAP_RT_SAME, SAP_RT_CROSS, SAP_RT_MIX} sap_rt_e;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Word length code to bit count
  function automatic logic [5:0] word_bits(input logic [1:0] code);
    case (code)
      2'h0:    word_bits = 6'h10;
      2'h1:    word_bits = 6'h14;
      2'h2:    word_bits = 6'h18;
      default: word_bits = 6'h20;
    endcase
  endfunction

endpackage

// [verilog/sap_sync.sv]
/*
  Two-flop synchroniser, W bits wide, each bit independent.
  Assumes every input is a level that stays put for at least two clocks.
*/
`timescale 1ns/1ps
module sap_sync #(
  parameter int W = 1  // Number of bits
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Levels in and out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] meta;  // First stage, read only by second
    logic [W-1:0] sync;  // Second stage
  } sap_sync_s;

  sap_sync_s r;       // Registered state
  sap_sync_s next_r;  // Next state

  if (W < 1) begin : g_chk
    $error("sap_sync: W must be at least 1");
  end

  // Chain the two stages
  always_comb begin
    next_r.meta = i_async;
    next_r.sync = r.meta;
  end

  // Register the state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_sync = r.sync;

endmodule // sap_sync

// [verilog/sap_port.sv]
/*
  Secondary audio serial port: settings over AXI4-Lite on i_mclk, framing,
  output source select and DAC routing on the link bit clock.
  Assumes the host drives bit clock and word clock; DSP words arrive on
  the link clock; settings change only while the port is idle.
*/
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module sap_port #(
  parameter int AW = 10  // AXI address width
) (
  // System clock and reset
  input  wire logic          i_mclk,
  input  wire logic          i_rst,
  // AXI4-Lite write address and data
  input  wire logic [AW-1:0] i_awaddr,
  input  wire logic          i_awvalid,
  output logic               o_awready,
  input  wire logic [31:0]   i_wdata,
  input  wire logic [3:0]    i_wstrb,
  input  wire logic          i_wvalid,
  output logic               o_wready,
  // AXI4-Lite write response
  output logic [1:0]         o_bresp,
  output logic               o_bvalid,
  input  wire logic          i_bready,
  // AXI4-Lite read
  input  wire logic [AW-1:0] i_araddr,
  input  wire logic          i_arvalid,
  output logic               o_arready,
  output logic [31:0]        o_rdata,
  output logic [1:0]         o_rresp,
  output logic               o_rvalid,
  input  wire logic          i_rready,
  // Serial link pins
  input  wire logic          i_link_bclk,
  input  wire logic          i_wclk,
  input  wire logic          i_sdin,
  input  wire logic          i_port1_sdin,
  input  wire logic          i_port3_sdin,
  output logic               o_sdout,
  output logic               o_sdout_oe,
  // Signal processor words, link clock domain, MSB aligned
  input  wire logic [31:0]   i_dsp_ch1,
  input  wire logic [31:0]   i_dsp_ch2,
  input  wire logic [31:0]   i_dsp_ch3,
  input  wire logic [31:0]   i_dsp_ch4,
  // DAC words, link clock domain, MSB aligned
  output logic [31:0]        o_dac_left,
  output logic [31:0]        o_dac_right,
  output logic               o_dac_valid
);

  // Index is taken from address bits 9:2, so narrower buses cannot work
  if (AW < 10 || AW > 32) begin : g_chk
    $error("sap_port: AW must be 10 to 32");
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------

  // Index decode shared by reads and writes
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx >= sap_pkg::IDX_FMT && idx <= sap_pkg::IDX_RSV_D)
              || idx == sap_pkg::IDX_STAT;
  endfunction

  // True when a slot starts at this bit clock
  function automatic logic slot_hit(input logic [2:0] fmt, input logic [5:0] wlb,
                                    input logic [7:0] ofs, input logic [8:0] fallpos,
                                    input logic lvl, input logic [8:0] cnt,
                                    input logic right);
    logic [8:0] rel;
    logic [8:0] pos;
    logic       ph;
    rel = lvl ? cnt : 9'(cnt - fallpos);
    pos = right ? 9'h000 : {1'b0, ofs};  // Offset moves first channel
    ph  = lvl;
    slot_hit = 1'b1;
    case (fmt)
      sap_pkg::SAP_I2S: begin  // One clock late, left while low
        ph  = right;
        pos = 9'(pos + 9'h001);
      end
      sap_pkg::SAP_LJF: begin  // At the edge, left while high
        ph = !right;
      end
      sap_pkg::SAP_RJF: begin  // Ends at the half frame
        ph  = !right;
        pos = 9'(pos + fallpos - {3'h0, wlb});
      end
      sap_pkg::SAP_DSP: begin  // Both words after the rising pulse
        rel = cnt;
        pos = right ? 9'({1'b0, ofs} + {3'h0, wlb}) : pos;
      end
      sap_pkg::SAP_MONO: begin  // One word after the rising pulse
        rel = cnt;
        slot_hit = !right;
      end
      default: slot_hit = 1'b0;  // Reserved codes send nothing
    endcase
    slot_hit = slot_hit && (lvl == ph) && (rel == pos);
  endfunction

  // Average of two signed words
  function automatic logic [31:0] mix(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] s;
    s   = {a[31], a} + {b[31], b};
    mix = s[32:1];
  endfunction

  // One DAC channel from its own and the other received word
  function automatic logic [31:0] route(input logic [1:0] sel, input logic [31:0] own,
                                        input logic [31:0] other);
    case (sel)
      sap_pkg::SAP_RT_SAME:  route = own;
      sap_pkg::SAP_RT_CROSS: route = other;
      sap_pkg::SAP_RT_MIX:   route = mix(own, other);
      default:               route = 32'h0000_0000;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // State of the bus side (i_mclk)
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        awready;  // Write address ready
    logic        wready;   // Write data ready
    logic        aw_ok;    // Address held
    logic        w_ok;     // Data held
    logic [7:0]  aw_idx;   // Held register index
    logic [7:0]  wbyte;    // Held low data byte
    logic        wen;      // Held lane zero strobe
    logic        bvalid;   // Write response valid
    logic [1:0]  bresp;    // Write response code
    logic        arready;  // Read address ready
    logic        rvalid;   // Read data valid
    logic [31:0] rdata;    // Read data
    logic [1:0]  rresp;    // Read response code
    logic [7:0]  fmt;      // Frame format control
    logic [7:0]  ofs;      // Data offset
    logic [7:0]  adc;      // Output path format control
    logic [7:0]  src;      // Output source select
    logic [7:0]  rt;       // DAC routing
    logic        req;      // Toggles on each write with the lane zero strobe
  } sap_bus_s;

  // ------------------------------------------------------------------
  // State of the link side (i_link_bclk)
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        ack;      // Last request toggle taken
    logic [7:0]  fmt;      // Settings copies
    logic [7:0]  ofs;
    logic [7:0]  adc;
    logic [7:0]  src;
    logic [7:0]  rt;
    logic        wprev;    // Word clock one clock ago
    logic        din;      // Data pin one clock ago, in step with wprev
    logic        seen;     // A frame has started
    logic [8:0]  cnt;      // Bit clocks since rising edge
    logic [8:0]  fallpos;  // Count where the low phase began
    logic [31:0] tsh;      // Transmit shifter
    logic [5:0]  tleft;    // Transmit bits still to send
    logic        sdout;    // Serial output bit
    logic        oe;       // Serial output enable
    logic [31:0] rsh;      // Receive shifter
    logic [5:0]  rleft;    // Receive bits still to take
    logic        rright;   // Receiving the right word
    logic [31:0] rl;       // Last left word
    logic [31:0] dl;       // Left DAC word
    logic [31:0] dr;       // Right DAC word
    logic        dvalid;   // DAC words fresh
  } sap_link_s;

  sap_bus_s  m;       // Bus side state
  sap_bus_s  next_m;  // Its next value
  sap_link_s l;       // Link side state
  sap_link_s next_l;  // Its next value
  logic [4:0] ls;     // Pins and request, on link clock
  logic [1:0] ms;     // Ack and seen, on bus clock

  // ------------------------------------------------------------------
  // Crossings
  // ------------------------------------------------------------------

  // Request toggle and pins into the link domain
  sap_sync #(.W(5)) u_lsync (
    .i_clk   (i_link_bclk),
    .i_rst   (i_rst),
    .i_async ({m.req, i_wclk, i_sdin, i_port1_sdin, i_port3_sdin}),
    .o_sync  (ls)
  );

  // Ack toggle and activity back to the bus domain
  sap_sync #(.W(2)) u_msync (
    .i_clk   (i_mclk),
    .i_rst   (i_rst),
    .i_async ({l.ack, l.seen}),
    .o_sync  (ms)
  );

  // ------------------------------------------------------------------
  // Bus side: AXI4-Lite slave and settings
  // ------------------------------------------------------------------

  // Next state of the bus side
  always_comb begin
    next_m = m;
    // Take address and data in either order
    if (i_awvalid && m.awready) begin
      next_m.aw_ok  = 1'b1;
      next_m.aw_idx = i_awaddr[9:2];
    end
    if (i_wvalid && m.wready) begin
      next_m.w_ok  = 1'b1;
      next_m.wbyte = i_wdata[7:0];
      next_m.wen   = i_wstrb[0];
    end
    // Retire the response
    if (m.bvalid && i_bready) begin
      next_m.bvalid = 1'b0;
    end
    // Both halves held: commit and answer
    if (m.aw_ok && m.w_ok && !m.bvalid) begin
      next_m.aw_ok  = 1'b0;
      next_m.w_ok   = 1'b0;
      next_m.bvalid = 1'b1;
      next_m.bresp  = is_mapped(m.aw_idx) ? sap_pkg::RESP_OKAY : sap_pkg::RESP_SLVERR;
      if (m.wen) begin
        // Reserved bits keep their zero default
        if (m.aw_idx == sap_pkg::IDX_FMT) begin
          next_m.fmt = m.wbyte & sap_pkg::WM_FMT;
        end else if (m.aw_idx == sap_pkg::IDX_OFS) begin
          next_m.ofs = m.wbyte & sap_pkg::WM_OFS;
        end else if (m.aw_idx == sap_pkg::IDX_ADC) begin
          next_m.adc = m.wbyte & sap_pkg::WM_ADC;
        end else if (m.aw_idx == sap_pkg::IDX_SRC) begin
          next_m.src = m.wbyte & sap_pkg::WM_SRC;
        end else if (m.aw_idx == sap_pkg::IDX_RT) begin
          next_m.rt = m.wbyte & sap_pkg::WM_RT;
        end
        // Any write with the lane zero strobe re-sends the whole set to the link
        next_m.req = !m.req;
      end
    end
    next_m.awready = !next_m.aw_ok && !next_m.bvalid;
    next_m.wready  = !next_m.w_ok && !next_m.bvalid;
    // Read: answer on the next clock
    if (m.rvalid && i_rready) begin
      next_m.rvalid = 1'b0;
    end
    if (i_arvalid && m.arready) begin
      next_m.rvalid = 1'b1;
      next_m.rresp  = sap_pkg::RESP_OKAY;
      next_m.rdata  = 32'h0000_0000;
      if (i_araddr[9:2] == sap_pkg::IDX_FMT) begin
        next_m.rdata[7:0] = m.fmt;
      end else if (i_araddr[9:2] == sap_pkg::IDX_OFS) begin
        next_m.rdata[7:0] = m.ofs;
      end else if (i_araddr[9:2] == sap_pkg::IDX_ADC) begin
        next_m.rdata[7:0] = m.adc;
      end else if (i_araddr[9:2] == sap_pkg::IDX_SRC) begin
        next_m.rdata[7:0] = m.src;
      end else if (i_araddr[9:2] == sap_pkg::IDX_RT) begin
        next_m.rdata[7:0] = m.rt;
      end else if (i_araddr[9:2] == sap_pkg::IDX_STAT) begin
        next_m.rdata[sap_pkg::ACT_POS]  = ms[0];
        next_m.rdata[sap_pkg::PEND_POS] = m.req != ms[1];
      end else if (!is_mapped(i_araddr[9:2])) begin
        next_m.rresp = sap_pkg::RESP_SLVERR;  // Unmapped
      end
    end
    next_m.arready = !next_m.rvalid;
  end

  // Register the bus side
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      m     <= '0;
      m.fmt <= sap_pkg::RST_FMT;  // I2S, 16 bits
      m.ofs <= sap_pkg::RST_OFS;
      m.adc <= sap_pkg::RST_ADC;
      m.src <= sap_pkg::RST_SRC;  // Output off
      m.rt  <= sap_pkg::RST_RT;   // Both DACs off
    end else begin
      m <= next_m;
    end
  end

  // ------------------------------------------------------------------
  // Link side: framing, transmit and receive
  // ------------------------------------------------------------------

  // Next state of the link side
  always_comb begin
    logic [2:0]  tfmt;  // Output path format
    logic [5:0]  twl;   // Output path bits
    logic [5:0]  rwl;   // Input path bits
    logic        thl;   // Transmit slot starts, left
    logic        thr;   // Transmit slot starts, right
    logic        rhl;   // Receive slot starts, left
    logic        rhr;   // Receive slot starts, right
    logic [31:0] word;  // Word to send
    logic [31:0] rw;    // Completed received word
    tfmt   = 3'h0;
    twl    = 6'h00;
    rwl    = 6'h00;
    thl    = 1'b0;
    thr    = 1'b0;
    rhl    = 1'b0;
    rhr    = 1'b0;
    word   = 32'h0000_0000;
    rw     = 32'h0000_0000;
    next_l = l;
    // Settings are stable when the toggle lands (bus waits on status)
    if (ls[4] != l.ack) begin
      next_l.ack = ls[4];
      next_l.fmt = m.fmt;
      next_l.ofs = m.ofs;
      next_l.adc = m.adc;
      next_l.src = m.src;
      next_l.rt  = m.rt;
    end
    // Output path takes its own set only under override
    tfmt = l.adc[sap_pkg::OVR_POS] ? l.adc[sap_pkg::FMT_POS +: 3]
                                   : l.fmt[sap_pkg::FMT_POS +: 3];
    twl  = sap_pkg::word_bits(l.adc[sap_pkg::OVR_POS] ? l.adc[sap_pkg::WL_POS +: 2]
                                                      : l.fmt[sap_pkg::WL_POS +: 2]);
    rwl  = sap_pkg::word_bits(l.fmt[sap_pkg::WL_POS +: 2]);
    // Bit count from the rising word clock edge
    next_l.wprev = ls[3];
    next_l.din   = ls[2];
    if (ls[3] && !l.wprev) begin
      next_l.cnt  = 9'h000;
      next_l.seen = 1'b1;
    end else if (l.cnt != 9'h1ff) begin
      next_l.cnt = 9'(l.cnt + 9'h001);
    end
    if (!ls[3] && l.wprev) begin
      next_l.fallpos = 9'(l.cnt + 9'h001);
    end
    thl = slot_hit(tfmt, twl, l.ofs, l.fallpos, l.wprev, l.cnt, 1'b0);
    thr = slot_hit(tfmt, twl, l.ofs, l.fallpos, l.wprev, l.cnt, 1'b1);
    rhl = slot_hit(l.fmt[sap_pkg::FMT_POS +: 3], rwl, l.ofs, l.fallpos, l.wprev, l.cnt, 1'b0);
    rhr = slot_hit(l.fmt[sap_pkg::FMT_POS +: 3], rwl, l.ofs, l.fallpos, l.wprev, l.cnt, 1'b1);
    // Pick the processor channel pair
    if (l.src[2:0] == sap_pkg::SAP_SRC_DSP34) begin
      word = thr ? i_dsp_ch4 : i_dsp_ch3;
    end else begin
      word = thr ? i_dsp_ch2 : i_dsp_ch1;
    end
    // Transmit
    case (l.src[2:0])
      sap_pkg::SAP_SRC_DSP12, sap_pkg::SAP_SRC_DSP34: begin
        if (thl || thr) begin  // MSB first, first bit now
          next_l.sdout = word[31];
          next_l.tsh   = {word[30:0], 1'b0};
          next_l.tleft = 6'(twl - 6'h01);
          next_l.oe    = 1'b1;
        end else if (l.tleft != 6'h00) begin
          next_l.sdout = l.tsh[31];
          next_l.tsh   = {l.tsh[30:0], 1'b0};
          next_l.tleft = 6'(l.tleft - 6'h01);
          next_l.oe    = 1'b1;
        end else begin  // Between words: release or hold low
          next_l.sdout = 1'b0;
          next_l.oe    = l.seen && !l.fmt[sap_pkg::TRI_POS];
        end
      end
      sap_pkg::SAP_SRC_LB1: begin  // Pin to pin loopback
        next_l.sdout = ls[1];
        next_l.oe    = 1'b1;
        next_l.tleft = 6'h00;
      end
      sap_pkg::SAP_SRC_LB2: begin
        next_l.sdout = ls[2];
        next_l.oe    = 1'b1;
        next_l.tleft = 6'h00;
      end
      sap_pkg::SAP_SRC_LB3: begin
        next_l.sdout = ls[0];
        next_l.oe    = 1'b1;
        next_l.tleft = 6'h00;
      end
      default: begin  // Off and reserved codes: released
        next_l.sdout = 1'b0;
        next_l.oe    = 1'b0;
        next_l.tleft = 6'h00;
      end
    endcase
    // Receive into the DAC path; delayed data bit matches the count
    next_l.dvalid = 1'b0;
    rw = {l.rsh[30:0], l.din} << (6'h20 - rwl);  // Left align
    if (rhl || rhr) begin
      next_l.rsh    = {31'h0, l.din};
      next_l.rleft  = 6'(rwl - 6'h01);
      next_l.rright = rhr;
    end else if (l.rleft != 6'h00) begin
      next_l.rsh   = {l.rsh[30:0], l.din};
      next_l.rleft = 6'(l.rleft - 6'h01);
      if (l.rleft == 6'h01) begin
        if (l.rright) begin  // Frame done: route
          next_l.dl     = route(l.rt[sap_pkg::LRT_POS +: 2], l.rl, rw);
          next_l.dr     = route(l.rt[sap_pkg::RRT_POS +: 2], rw, l.rl);
          next_l.dvalid = 1'b1;
        end else if (l.fmt[sap_pkg::FMT_POS +: 3] == sap_pkg::SAP_MONO) begin
          next_l.dl     = route(l.rt[sap_pkg::LRT_POS +: 2], rw, rw);
          next_l.dr     = route(l.rt[sap_pkg::RRT_POS +: 2], rw, rw);
          next_l.dvalid = 1'b1;
        end else begin
          next_l.rl = rw;
        end
      end
    end
  end

  // Register the link side
  always_ff @(posedge i_link_bclk or posedge i_rst) begin
    if (i_rst) begin
      l     <= '0;
      l.fmt <= sap_pkg::RST_FMT;
      l.ofs <= sap_pkg::RST_OFS;
      l.adc <= sap_pkg::RST_ADC;
      l.src <= sap_pkg::RST_SRC;
      l.rt  <= sap_pkg::RST_RT;
    end else begin
      l <= next_l;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all straight from flops
  // ------------------------------------------------------------------
  assign o_awready   = m.awready;
  assign o_wready    = m.wready;
  assign o_bresp     = m.bresp;
  assign o_bvalid    = m.bvalid;
  assign o_arready   = m.arready;
  assign o_rdata     = m.rdata;
  assign o_rresp     = m.rresp;
  assign o_rvalid    = m.rvalid;
  assign o_sdout     = l.sdout;
  assign o_sdout_oe  = l.oe;
  assign o_dac_left  = l.dl;
  assign o_dac_right = l.dr;
  assign o_dac_valid = l.dvalid;

endmodule // sap_port

// [bench/sap_port_sva.sv]
/* Bus handshake and link pulse checks on sap_port ports.
   Assumes bind onto every sap_port instance. */
`timescale 1ns/1ps
module sap_port_sva (
  // Clocks and reset
  input wire logic        i_mclk, i_link_bclk, i_rst,
  // Bus handshakes
  input wire logic        i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready,
  input wire logic        i_arvalid, o_arready, o_rvalid, i_rready, o_dac_valid,
  input wire logic [31:0] o_rdata
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // Bus transfers
  // ----------------------------------------
  sequence wtake; i_awvalid && o_awready && i_wvalid && o_wready; endsequence
  sequence rtake; i_arvalid && o_arready; endsequence
  upper_zero_a: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  wr_resp_a: assert property (wtake |-> ##[1:2] o_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (rtake |=> o_rvalid)
    else $error("read data late");
  b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response dropped");
  r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  ar_low_a: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted while busy");
  aw_low_a: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while busy");
  // Word updates are single link clock pulses
  dac_pulse_a: assert property (@(posedge i_link_bclk) o_dac_valid |=> !o_dac_valid)
    else $error("dac valid longer than one clock");
endmodule // sap_port_sva
bind sap_port sap_port_sva u_sap_port_sva (.*);

// [bench/sap_host.sv]
/* Host audio processor: makes 48 ns bit clock and word clock, sends a
   64-bit frame, gathers bits the port drives. Assumes a continuous stream. */
`timescale 1ns/1ps
module sap_host (
  input  wire logic [63:0] i_frame,  // First bit sent at the top
  input  wire logic        i_sdout,
  input  wire logic        i_oe,
  output logic             o_bclk,
  output logic             o_wclk,
  output logic             o_sdin,
  output logic [31:0]      o_cap     // Last 32 driven bits
);
  int k = 0;  // Bit position in frame
  initial {o_bclk, o_wclk, o_sdin, o_cap} = '0;
  always #24 o_bclk = ~o_bclk;
  // Word clock high in first half, data changes on falling edge
  always @(negedge o_bclk) begin
    o_wclk <= (k < 32);
    o_sdin <= i_frame[63-k];
    k <= (k + 1) % 64;
  end
  // Only bits actually driven are kept
  always @(posedge o_bclk) if (i_oe) o_cap <= {o_cap[30:0], i_sdout};
endmodule // sap_host

// [bench/sap_port_tb.sv]
/* Bench for sap_port: AXI4-Lite tasks, frame stream from sap_host.
   Assumes checker and host model are compiled first. */
`timescale 1ns/1ps
module sap_port_tb;
  logic i_mclk = 0, i_rst = 1, aw = 0, w = 0, ar = 0, p1 = 0, p3 = 0, br = 0, rre = 0;
  logic [9:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdv, rd_d, cap, dl, dr;
  logic [1:0] rr, rd_r, brsp, wr_b;
  logic awr, wrr, bv, arr, rv, bclk, wclk, sdin, sdo, oe, dv;
  logic [31:0] ch [4] = '{32'h1111aaaa, 32'h2222bbbb, 32'h3333cccc, 32'h4444dddd};
  int miscompares = 0, n_checks = 0;
  localparam logic [63:0] FRM = {1'b0, 16'h3000, 16'h0, 16'h1000, 15'h0};
  sap_port u_sap_port (.i_mclk, .i_rst, .i_awaddr(awa), .i_awvalid(aw), .o_awready(awr),
    .i_wdata(wd), .i_wstrb(4'h1), .i_wvalid(w), .o_wready(wrr), .o_bresp(brsp), .o_bvalid(bv),
    .i_bready(br), .i_araddr(ara), .i_arvalid(ar), .o_arready(arr), .o_rdata(rdv),
    .o_rresp(rr), .o_rvalid(rv), .i_rready(rre), .i_link_bclk(bclk), .i_wclk(wclk),
    .i_sdin(sdin), .i_port1_sdin(p1), .i_port3_sdin(p3), .o_sdout(sdo), .o_sdout_oe(oe),
    .i_dsp_ch1(ch[0]), .i_dsp_ch2(ch[1]), .i_dsp_ch3(ch[2]), .i_dsp_ch4(ch[3]),
    .o_dac_left(dl), .o_dac_right(dr), .o_dac_valid(dv));
  sap_host u_sap_host (.i_frame(FRM), .i_sdout(sdo), .i_oe(oe), .o_bclk(bclk),
    .o_wclk(wclk), .o_sdin(sdin), .o_cap(cap));
  always #10 i_mclk = ~i_mclk;
  task automatic chk(input logic [63:0] g, e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] ix);
    ara <= {ix, 2'h0}; ar <= 1;
    do @(posedge i_mclk); while (!arr);
    ar <= 0;
    do @(posedge i_mclk); while (!rv);
    rre <= 1;  // Late ready exercises the hold check
    @(posedge i_mclk);
    rd_d = rdv; rd_r = rr; rre <= 0;
  endtask
  // Waits for settings to reach the link before returning
  task automatic wr(input logic [7:0] ix, d);
    bit ad = 0, dd = 0;
    awa <= {ix, 2'h0}; wd <= {24'h0, d}; aw <= 1; w <= 1;
    do begin
      @(posedge i_mclk);
      if (awr) aw <= 0;
      if (wrr) w <= 0;
      ad |= awr; dd |= wrr;
    end while (!(ad && dd));
    do @(posedge i_mclk); while (!bv);
    br <= 1;
    @(posedge i_mclk);
    wr_b = brsp; br <= 0;
    do rd(8'h1f); while (rd_d[1] !== 1'b0);
  endtask
  // Counts link clocks driven, matching v unless any is set
  task automatic cnt(input logic v, any, input int e);
    int c = 0;
    repeat (128) @(posedge bclk);
    repeat (64) @(posedge bclk) c += (oe === 1'b1 && (any || sdo === v));
    chk(c, e);
    @(posedge i_mclk);
  endtask
  task automatic cap_chk(input logic [31:0] e);
    repeat (128) @(posedge bclk);
    @(negedge oe) #1 chk(cap, e);
    @(posedge i_mclk);
  endtask
  task automatic t_route();
    logic [7:0] rt [3] = '{8'h60, 8'h90, 8'hf0};
    logic [63:0] ex [3] = '{{2{32'h10000000}}, {2{32'h30000000}}, {2{32'h20000000}}};
    chk({dl, dr}, 0);
    foreach (rt[i]) begin
      wr(8'h18, rt[i]);
      repeat (192) @(posedge bclk);
      @(posedge dv) @(negedge bclk) chk({dl, dr}, ex[i]);
      @(posedge i_mclk);
    end
    // DSP, offset one: left is the 3000 word, right is zero, mixed
    wr(8'h11, 8'h20); wr(8'h12, 8'h01);
    repeat (192) @(posedge bclk);
    @(posedge dv) @(negedge bclk) chk({dl, dr}, {2{32'h18000000}});
    @(posedge i_mclk);
  endtask
  task automatic t_regs();
    // Legal codes only, reserved bits and registers zero
    logic [7:0] m [9] = '{8'h99, 8'hff, 0, 0, 8'h9c, 0, 8'h05, 8'hf0, 0};
    for (int i = 0; i < 9; i++) begin
      wr(8'h11 + 8'(i), 8'h00); chk(wr_b, 0); rd(8'h11 + 8'(i)); chk(rd_d, 0);
      wr(8'h11 + 8'(i), m[i]); rd(8'h11 + 8'(i)); chk(rd_d, m[i]);
    end
    rd(8'h05); chk(rd_r, 2'h2);
    for (int i = 0; i < 9; i++) wr(8'h11 + 8'(i), 8'h00);
  endtask
  task automatic t_dsp();
    wr(8'h11, 8'h21); wr(8'h17, 8'h01); cap_chk(32'h11112222);
    wr(8'h17, 8'h05); cap_chk(32'h33334444);
    wr(8'h15, 8'h34); cap_chk(32'hcc4444dd);
    wr(8'h15, 8'h30); cap_chk(32'h33334444);
    wr(8'h11, 8'h20); cnt(0, 1, 64);
  endtask
  task automatic t_loop();
    p1 <= 1;
    wr(8'h17, 8'h02); cnt(1, 0, 64);
    wr(8'h17, 8'h03); cnt(1, 0, 3);
    wr(8'h17, 8'h04); cnt(0, 0, 64);
    wr(8'h17, 8'h00); cnt(0, 1, 0);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge i_mclk);
    i_rst <= 0;
    @(posedge i_mclk);
    t_route(); t_regs(); t_dsp(); t_loop();
    end_sim();
  end
  // Whole run needs well under a millisecond
  initial begin
    #1ms;
    miscompares++;
    end_sim();
  end
endmodule // sap_port_tb
